// [hw/sss_consts.vh]
// Constants of the setpoint source selector: register map, codes, fields
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH
// Register offsets (word index on the plain port)
`define SSS_REG_TRIG_A 4'h0
`define SSS_REG_TRIG_B 4'h1
`define SSS_REG_CFG 4'h2
`define SSS_REG_KEYPAD 4'h3
`define SSS_REG_STATUS 4'h4
`define SSS_REG_SETPOINT 4'h5
`define SSS_REG_DIN 4'h6
`define SSS_REG_PRESET 4'h8
// Trigger source codes
`define SSS_SRC_NEVER 5'h00
`define SSS_SRC_ALWAYS 5'h01
`define SSS_SRC_DIN_FIRST 5'h0B
`define SSS_SRC_DIN_LAST 5'h0E
// Trigger slot positions in TRIG_A (five bits each)
`define SSS_SLOT_RUN 0
`define SSS_SLOT_REV 1
`define SSS_SLOT_AI1 2
`define SSS_SLOT_AI2 3
`define SSS_SLOT_KEY 4
// Trigger slot positions in TRIG_B
`define SSS_SLOT_PB0 0
`define SSS_SLOT_PB1 1
`define SSS_SLOT_PB2 2
`define SSS_SLOT_PB3 3
// Default source codes
`define SSS_DEF_KEYPAD 2'h1
`define SSS_DEF_AI1 2'h2
`define SSS_DEF_AI2 2'h3
// Control modes selecting the preset table
`define SSS_MODE_FREQ 2'h0
`define SSS_MODE_PROC 2'h1
`define SSS_MODE_TORQ 2'h2
// Stop methods
`define SSS_STOP_COAST 1'h0
`define SSS_STOP_RAMP 1'h1
// Active source codes reported in status
`define SSS_ACT_KEYPAD 3'h1
`define SSS_ACT_AI1 3'h2
`define SSS_ACT_AI2 3'h3
`define SSS_ACT_PRESET 3'h4
`define SSS_ACT_NET 3'h5
// Reset values
`define SSS_RST_TRIG_A 32'h00000000
`define SSS_RST_TRIG_B 32'h00000000
`define SSS_RST_CFG 32'h00000003
`define SSS_RST_KEYPAD 16'h00C8
`define SSS_KEY_STEP 16'h0001
`endif

// [hw/sss_trigger_map.v]
// Trigger source decoder: maps one source code to an active level
`timescale 1ns/1ps
`include "sss_consts.vh"
module sss_trigger_map (
  // Source code and digital inputs
  input wire [4:0] code,
  input wire [3:0] din,
  // Decoded level
  output reg active
);
  // Codes outside the known set read as never active
  always @* begin
    active = 1'b0;
    if (code == `SSS_SRC_ALWAYS) begin // R11
      active = 1'b1;
    end else if (code >= `SSS_SRC_DIN_FIRST && code <= `SSS_SRC_DIN_LAST) begin // R11
      active = din[code[1:0] - 2'h3];
    end
  end
endmodule // sss_trigger_map

// [hw/sss_selector.v]
// Setpoint source selector: trigger mapping, priority, presets, run and direction
//
// Overview of operation
// R01: No trigger or preset: use default source
// R02: Both analog triggers: analog input one wins
// R03: Run trigger drives forward; release stops motor
// R04: Reverse trigger turns motor the other way
// R05: Keypad trigger overrides default; clears to default
// R06: Keypad active: up/down keys adjust keypad setpoint (code: only while motor_run is high)
// R07: Four preset bits form binary preset number
// R08: All preset bits false: no preset selected
// R09: Preset value from table of control mode
// R10: Nonzero preset overrides keypad source
// R11: Codes: 0 never, 1 always, 11-14 inputs
// R12: Presets 8-15 need bit-3 input wired externally
// R13: Earlier selection trigger beats later ones
// R14: Network mode ignores local selection triggers
// R15: Sample every cycle; switch next cycle cleanly
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sss_consts.vh"
module sss_selector #(
  parameter SP_W = 16,
  parameter NPRESET = 15
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [3:0] reg_addr_hi,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Field inputs
  input wire [3:0] digital_in,
  input wire [SP_W-1:0] analog_input_one,
  input wire [SP_W-1:0] analog_input_two,
  input wire [SP_W-1:0] network_setpoint,
  input wire network_mode_flag,
  input wire key_up,
  input wire key_down,
  // Motor setpoint path
  output reg [SP_W-1:0] setpoint_out,
  output reg motor_run,
  output reg motor_reverse,
  output reg stop_ramp,
  output reg [2:0] active_source
);
  // Configuration registers
  reg [31:0] trig_a_reg;
  reg [31:0] trig_b_reg;
  reg [31:0] cfg_reg;
  reg [SP_W-1:0] keypad_reg;
  reg [SP_W-1:0] keypad_next;
  reg [SP_W-1:0] ptab_reg [0:3*NPRESET-1];
  reg [3:0] din_reg;
  reg key_up_reg;
  reg key_down_reg;
  reg up_prev_reg;
  reg down_prev_reg;
  reg [SP_W-1:0] sp_next;
  reg [2:0] src_next;
  reg [3:0] preset_num;
  reg [5:0] ptab_idx;
  wire [8:0] trig;
  wire [1:0] def_src;
  wire [1:0] ctrl_mode;

  assign def_src = cfg_reg[1:0];
  assign ctrl_mode = cfg_reg[3:2];

  // One decoder per trigger slot, on registered inputs
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_trig_a
      sss_trigger_map u_map (
        .code(trig_a_reg[5*g+4:5*g]),
        .din(din_reg),
        .active(trig[g])
      );
    end
    for (g = 0; g < 4; g = g + 1) begin : g_trig_b
      sss_trigger_map u_map (
        .code(trig_b_reg[5*g+4:5*g]),
        .din(din_reg),
        .active(trig[5+g])
      );
    end
  endgenerate

  // Register writes and input sampling
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_a_reg <= `SSS_RST_TRIG_A;
      trig_b_reg <= `SSS_RST_TRIG_B;
      cfg_reg <= `SSS_RST_CFG;
      din_reg <= 4'h0;
      key_up_reg <= 1'b0;
      key_down_reg <= 1'b0;
      up_prev_reg <= 1'b0;
      down_prev_reg <= 1'b0;
    end else begin
      din_reg <= digital_in; // R15
      key_up_reg <= key_up;
      key_down_reg <= key_down;
      up_prev_reg <= key_up_reg;
      down_prev_reg <= key_down_reg;
      if (reg_wr && reg_addr_hi == 4'h0) begin
        case (reg_addr)
          `SSS_REG_TRIG_A: trig_a_reg <= {7'h00, reg_wdata[24:0]};
          `SSS_REG_TRIG_B: trig_b_reg <= {12'h000, reg_wdata[19:0]};
          `SSS_REG_CFG: cfg_reg <= {27'h0000000, reg_wdata[4:0]};
          default: ;
        endcase
      end
    end
  end

  // Preset tables: address hi 1..3 selects table, low nibble the preset 1..15
  always @(posedge clk) begin
    if (reg_wr && reg_addr_hi != 4'h0 && reg_addr_hi[3:2] == 2'b00 && reg_addr != 4'h0) begin
      ptab_reg[(reg_addr_hi[1:0] - 2'h1) * NPRESET + reg_addr - 1] <= reg_wdata[SP_W-1:0];
    end
  end

  // Keypad setpoint: software write, or edge of arrow key while keypad rules and the motor runs
  always @* begin
    keypad_next = keypad_reg;
    if (active_source == `SSS_ACT_KEYPAD && motor_run) begin
      if (key_up_reg && !up_prev_reg && keypad_reg != {SP_W{1'b1}}) begin // R06
        keypad_next = keypad_reg + `SSS_KEY_STEP;
      end else if (key_down_reg && !down_prev_reg && keypad_reg != {SP_W{1'b0}}) begin // R06
        keypad_next = keypad_reg - `SSS_KEY_STEP;
      end
    end
    if (reg_wr && reg_addr_hi == 4'h0 && reg_addr == `SSS_REG_KEYPAD) begin
      keypad_next = reg_wdata[SP_W-1:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      keypad_reg <= `SSS_RST_KEYPAD;
    end else begin
      keypad_reg <= keypad_next;
    end
  end

  // Source priority; decided fully before the output register, so no glitch
  always @* begin
    preset_num = {trig[8], trig[7], trig[6], trig[5]}; // R07 R12
    ptab_idx = 6'h00;
    src_next = `SSS_ACT_KEYPAD;
    sp_next = keypad_reg;
    case (def_src) // R01
      `SSS_DEF_AI1: begin
        src_next = `SSS_ACT_AI1;
        sp_next = analog_input_one;
      end
      `SSS_DEF_AI2: begin
        src_next = `SSS_ACT_AI2;
        sp_next = analog_input_two;
      end
      default: begin
        src_next = `SSS_ACT_KEYPAD;
        sp_next = keypad_reg;
      end
    endcase
    if (network_mode_flag) begin // R14
      src_next = `SSS_ACT_NET;
      sp_next = network_setpoint;
    end else if (preset_num != 4'h0) begin // R08 R10
      ptab_idx = ctrl_mode[1] ? 6'd30 : (ctrl_mode[0] ? 6'd15 : 6'd0);
      ptab_idx = ptab_idx + {2'b00, preset_num} - 6'd1; // R09
      src_next = `SSS_ACT_PRESET;
      sp_next = ptab_reg[ptab_idx];
    end else if (trig[`SSS_SLOT_AI1]) begin // R02 R13
      src_next = `SSS_ACT_AI1;
      sp_next = analog_input_one;
    end else if (trig[`SSS_SLOT_AI2]) begin // R13
      src_next = `SSS_ACT_AI2;
      sp_next = analog_input_two;
    end else if (trig[`SSS_SLOT_KEY]) begin // R05
      src_next = `SSS_ACT_KEYPAD;
      sp_next = keypad_reg;
    end
  end

  // Output registers: one cycle after the sampled trigger change
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      setpoint_out <= {SP_W{1'b0}};
      active_source <= `SSS_ACT_KEYPAD;
      motor_run <= 1'b0;
      motor_reverse <= 1'b0;
      stop_ramp <= 1'b1;
    end else begin
      setpoint_out <= sp_next; // R15
      active_source <= src_next; // R15
      motor_run <= trig[`SSS_SLOT_RUN]; // R03
      motor_reverse <= trig[`SSS_SLOT_REV]; // R04
      stop_ramp <= cfg_reg[4]; // R03
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd && reg_addr_hi == 4'h0) begin
        case (reg_addr)
          `SSS_REG_TRIG_A: reg_rdata <= trig_a_reg;
          `SSS_REG_TRIG_B: reg_rdata <= trig_b_reg;
          `SSS_REG_CFG: reg_rdata <= cfg_reg;
          `SSS_REG_KEYPAD: reg_rdata <= {{(32-SP_W){1'b0}}, keypad_reg};
          `SSS_REG_STATUS: reg_rdata <= {18'h00000, trig, motor_reverse, motor_run,
            active_source};
          `SSS_REG_SETPOINT: reg_rdata <= {{(32-SP_W){1'b0}}, setpoint_out};
          `SSS_REG_DIN: reg_rdata <= {28'h0000000, din_reg};
          default: reg_rdata <= 32'h00000000;
        endcase
      end else if (reg_rd && reg_addr_hi != 4'h0 && reg_addr_hi[3:2] == 2'b00
        && reg_addr != 4'h0) begin
        reg_rdata <= {{(32-SP_W){1'b0}},
          ptab_reg[(reg_addr_hi[1:0] - 2'h1) * NPRESET + reg_addr - 1]};
      end
    end
  end
endmodule // sss_selector

// [verification/sss_operator.sv]
// Operator switch panel and analog sources in front of the selector
`timescale 1ns/1ps
module sss_operator #(
  parameter logic [15:0] AI1_LVL = 16'h0111,
  parameter logic [15:0] AI2_LVL = 16'h0222
) (
  // Switch positions
  input wire logic [3:0] sw,
  // Terminals
  output logic [3:0] digital_in,
  output logic [15:0] ai1,
  output logic [15:0] ai2
);
  // All four terminals wired, so presets 8 to 15 stay reachable
  assign digital_in = sw;
  assign ai1 = AI1_LVL;
  assign ai2 = AI2_LVL;
endmodule // sss_operator

// [verification/sss_chk.sv]
// Port checker of the setpoint source selector
`timescale 1ns/1ps
module sss_chk #(
  parameter SP_W = 16
) (
  // Clock, reset, register port
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr_hi,
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Field side
  input wire [3:0] digital_in,
  input wire [SP_W-1:0] analog_input_one,
  input wire [SP_W-1:0] analog_input_two,
  input wire [SP_W-1:0] network_setpoint,
  input wire network_mode_flag,
  input wire [SP_W-1:0] setpoint_out,
  input wire motor_run,
  input wire motor_reverse,
  input wire [2:0] active_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_NET_SRC: assert property (network_mode_flag[*3] |-> active_source == 3'h5)
    else $error("network mode not selected");
  AST_NET_VAL: assert property ((network_mode_flag[*3] ##0 $stable(network_setpoint))
    |-> setpoint_out == network_setpoint) else $error("network value not passed");
  AST_AI1_VAL: assert property (active_source == 3'h2 && $past(active_source) == 3'h2
    |-> setpoint_out == $past(analog_input_one)) else $error("input one value wrong");
  AST_AI2_VAL: assert property (active_source == 3'h3 && $past(active_source) == 3'h3
    |-> setpoint_out == $past(analog_input_two)) else $error("input two value wrong");
  AST_IDLE_RD: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (reg_rd && reg_addr_hi == 4'h0 && reg_addr == 4'hF
    |=> reg_rdata == 32'h00000000) else $error("unmapped read not zero");
  // Quiet inputs must leave the selection untouched: no glitch through sources
  AST_STEADY: assert property ((!reg_wr && $stable(digital_in) && !$past(rst) &&
    $stable(network_mode_flag))[*3] |-> $stable({active_source, motor_run, motor_reverse}))
    else $error("outputs moved without cause");
  AST_SRC_RANGE: assert property (active_source >= 3'h1 && active_source <= 3'h5)
    else $error("source code out of range");
  C_PRESET: cover property (active_source == 3'h4);
  C_REV: cover property (active_source == 3'h2 && motor_reverse);
  C_NET: cover property (network_mode_flag[*3]);
endmodule // sss_chk
bind sss_selector sss_chk #(.SP_W(SP_W)) sss_chk_inst (.clk(clk), .rst(rst),
  .reg_addr_hi(reg_addr_hi), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .digital_in(digital_in), .analog_input_one(analog_input_one),
  .analog_input_two(analog_input_two), .network_setpoint(network_setpoint),
  .network_mode_flag(network_mode_flag), .setpoint_out(setpoint_out),
  .motor_run(motor_run), .motor_reverse(motor_reverse), .active_source(active_source));

// [verification/testbench.sv]
// Self-checking bench of the setpoint source selector
`timescale 1ns/1ps
module testbench;
  logic clk, rst, reg_wr, reg_rd, nflag, kup, kdn, run, rev, ramp;
  logic [3:0] ahi, alo, sw, din;
  logic [31:0] wd, rdat;
  logic [15:0] ai1, ai2, sp;
  logic [2:0] src;
  int miscompares, check_count, cyc;
  sss_selector sss_selector_inst (.clk(clk), .rst(rst), .reg_addr_hi(ahi), .reg_addr(alo),
    .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat), .digital_in(din),
    .analog_input_one(ai1), .analog_input_two(ai2), .network_setpoint(16'h0777),
    .network_mode_flag(nflag), .key_up(kup), .key_down(kdn), .setpoint_out(sp),
    .motor_run(run), .motor_reverse(rev), .stop_ramp(ramp), .active_source(src));
  sss_operator sss_operator_inst (.sw(sw), .digital_in(din), .ai1(ai1), .ai2(ai2));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] h, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ahi <= h; alo <= a; wd <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    ahi <= 4'h0; alo <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(rdat, e);
  endtask
  // Set switches, let sampling and output stages settle, judge source
  task sel(input logic [3:0] s, input logic [2:0] es, input logic [15:0] ep);
    @(posedge clk);
    sw <= s;
    repeat (3) @(posedge clk);
    #1 chk(src, es);
    chk(sp, ep);
  endtask
  // Single press of one arrow key: held high for one clock only, so the keypad setpoint should step once
  task key(input logic u);
    @(posedge clk);
    if (u) kup <= 1'b1;
    else kdn <= 1'b1;
    @(posedge clk);
    kup <= 1'b0;
    kdn <= 1'b0;
  endtask
  task t_reset;
    rd(4'h2, 32'h00000003);
    rd(4'hF, 32'h00000000);
    rd(4'h4, 32'h00000003);
    chk(src, 3'h3);
    chk(sp, 16'h0222);
  endtask
  task t_ex1;
    wr(4'h0, 4'h2, 32'h00000011);
    wr(4'h0, 4'h0, 32'h0007358B);
    sel(4'h0, 3'h1, 16'h00C8);
    sel(4'h1, 3'h1, 16'h00C8);
    chk({rev, run}, 2'h1);
    sel(4'h3, 3'h1, 16'h00C8);
    chk({rev, run}, 2'h3);
    sel(4'h5, 3'h2, 16'h0111);
    sel(4'h9, 3'h3, 16'h0222);
    sel(4'hD, 3'h2, 16'h0111);
    sel(4'h0, 3'h1, 16'h00C8);
    chk({ramp, rev, run}, 3'h4);
    wr(4'h0, 4'h0, 32'h00000001);
    sel(4'h0, 3'h1, 16'h00C8);
    chk(run, 1'b1);
  endtask
  task t_ex2;
    wr(4'h0, 4'h2, 32'h00000002);
    wr(4'h0, 4'h0, 32'h00D0000B);
    sel(4'h1, 3'h2, 16'h0111);
    chk({ramp, run}, 2'h1);
    sel(4'h5, 3'h1, 16'h00C8);
    key(1'b1);
    sel(4'h5, 3'h1, 16'h00C9);
    rd(4'h3, 32'h000000C9);
    key(1'b0);
    sel(4'h5, 3'h1, 16'h00C8);
    sel(4'h1, 3'h2, 16'h0111);
  endtask
  task t_preset;
    wr(4'h0, 4'h2, 32'h00000001);
    wr(4'h0, 4'h1, 32'h0007358B);
    for (int n = 1; n < 16; n++) begin
      wr(4'h1, n[3:0], 32'h00000100 + n);
    end
    for (int n = 1; n < 16; n++) begin
      sel(n[3:0], 3'h4, 16'h0100 + n[15:0]);
    end
    sel(4'h0, 3'h1, 16'h00C8);
    wr(4'h2, 4'h7, 32'h00000207);
    wr(4'h0, 4'h2, 32'h00000005);
    sel(4'h7, 3'h4, 16'h0207);
    wr(4'h3, 4'h7, 32'h00000307);
    wr(4'h0, 4'h2, 32'h00000009);
    sel(4'h7, 3'h4, 16'h0307);
    @(posedge clk);
    nflag <= 1'b1;
    sel(4'h7, 3'h5, 16'h0777);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle ceiling against a hung run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      final_report;
    end
  end
  // Main sequence
  initial begin
    {rst, reg_wr, reg_rd, nflag, kup, kdn} = 6'h20;
    {ahi, alo, sw, wd} = 44'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_ex1;
    t_ex2;
    t_preset;
    final_report;
  end
endmodule // testbench
